// ---- rtl/sso_defines.svh ----
// Constants for the servo status output selector: digit codes, reset values, widths.
// Assumes inclusion by bare name from the package and the module.
`ifndef SSO_DEFINES_SVH
`define SSO_DEFINES_SVH
`define SSO_FN_INPOS 4'h0
`define SSO_FN_TURNING 4'h1
`define SSO_FN_READY 4'h2
`define SSO_FN_TQLIM 4'h3
`define SSO_FN_BRAKE 4'h4
`define SSO_FN_INDEX 4'h5
`define SSO_FN_TRAVEL 4'h6
`define SSO_FN_EXCITE 4'h7
`define SSO_FN_HOME 4'h8
`define SSO_SEL_RESET 12'h210
`define SSO_OTSET_RESET 16'h0000
`define SSO_DIG_FWD_LSB 4
`define SSO_DIG_REV_LSB 8
`define SSO_DIG_PAIR1112_LSB 0
`define SSO_DIG_PAIR0506_LSB 4
`define SSO_DIG_PAIR0910_LSB 8
`define SSO_RPM_W 16
`define SSO_TRQ_W 16
`define SSO_TURN_THR_RESET 16'h0014
`define SSO_SYNC_RESET 2'h0
`define SSO_PINS_RESET 3'h7
`define SSO_STAT_RESET 1'b1
`define SSO_DIS_RESET 1'b0
`define SSO_CAP_RESET 1'b0
`endif

// ---- rtl/sso_pkg.sv ----
// Types shared by the servo status output selector.
// Assumes the constants header is on the include path.
`include "sso_defines.svh"
package sso_pkg;
    typedef struct packed {
        logic in_position;
        logic servo_ready;
        logic brake_release;
        logic index_pulse;
        logic home_done;
    } sso_drive_status_t;

    typedef struct packed {
        logic pair_0910_n;
        logic pair_0506_n;
        logic pair_1112_n;
    } sso_pins_t;
endpackage : sso_pkg

// ---- rtl/sso_top.sv ----
// Servo status output selector: builds the overtravel, excitation, torque-limit and
// rotation-detect indications and routes nine status functions onto three pin pairs.
// Assumes settings are BCD digits and all status inputs come from logic on mclk, except
// the two prohibit inputs, which come from pins.
`timescale 1ns/1ps
`include "sso_defines.svh"
module sso_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [11:0] output_select_setting,
    input wire logic [15:0] overtravel_setting,
    input wire logic [`SSO_RPM_W-1:0] rotation_detect_threshold,
    input wire logic fwd_prohibit_in,
    input wire logic rev_prohibit_in,
    input wire logic servo_excited,
    input wire logic [`SSO_TRQ_W-1:0] torque_ref_abs,
    input wire logic [`SSO_TRQ_W-1:0] torque_limit_setting,
    input wire logic [`SSO_RPM_W-1:0] motor_speed_abs,
    input wire sso_pkg::sso_drive_status_t drive_status,
    output sso_pkg::sso_pins_t pins_n,
    output logic overtravel_out,
    output logic torque_limit_out,
    output logic rotation_detect_out
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Pulls one BCD digit out of a setting word.
    function automatic logic [3:0] digit_at(
        input logic [15:0] word,
        input int lsb
    );
        logic [3:0] d;
        d = word[lsb +: 4];
        return d;
    endfunction : digit_at

    // A disable digit only counts when it holds exactly one.
    function automatic logic digit_is_one(
        input logic [3:0] d
    );
        logic r;
        r = (d == 4'h1);
        return r;
    endfunction : digit_is_one

    // Strictly above: an equal value leaves the indication inactive.
    function automatic logic exceeds(
        input logic [`SSO_TRQ_W-1:0] value,
        input logic [`SSO_TRQ_W-1:0] limit
    );
        logic r;
        r = (value > limit);
        return r;
    endfunction : exceeds

    // Codes above eight have no function and leave the pair high.
    function automatic logic pick_fn(
        input logic [3:0] code,
        input logic [8:0] f_n
    );
        logic r;
        r = 1'b1;
        if (code <= `SSO_FN_HOME) begin
            r = f_n[code];
        end
        return r;
    endfunction : pick_fn

    // ************************************************************
    // Restart capture
    // ************************************************************
    logic [11:0] sel_q;
    logic [11:0] sel_d;
    logic fwd_dis_q;
    logic fwd_dis_d;
    logic rev_dis_q;
    logic rev_dis_d;
    logic cap_done_q;
    logic cap_done_d;

    // The select and overtravel settings are taken on the first edge after reset release and then held, so a
    // change while running only shows after the next restart.
    always_comb begin
        sel_d = sel_q;
        fwd_dis_d = fwd_dis_q;
        rev_dis_d = rev_dis_q;
        cap_done_d = 1'b1;
        if (!cap_done_q) begin
            sel_d = output_select_setting;
            fwd_dis_d = digit_is_one(digit_at(overtravel_setting, `SSO_DIG_FWD_LSB));
            rev_dis_d = digit_is_one(digit_at(overtravel_setting, `SSO_DIG_REV_LSB));
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= `SSO_SEL_RESET;
            fwd_dis_q <= `SSO_DIS_RESET;
            rev_dis_q <= `SSO_DIS_RESET;
            cap_done_q <= `SSO_CAP_RESET;
        end else begin
            sel_q <= sel_d;
            fwd_dis_q <= fwd_dis_d;
            rev_dis_q <= rev_dis_d;
            cap_done_q <= cap_done_d;
        end
    end

    // ************************************************************
    // Prohibit pin synchronisers
    // ************************************************************
    logic [1:0] fwd_s_q;
    logic [1:0] fwd_s_d;
    logic [1:0] rev_s_q;
    logic [1:0] rev_s_d;
    logic fwd_seen;
    logic rev_seen;

    // Only the second stage is read, so a metastable first stage never reaches logic.
    always_comb begin
        fwd_s_d = {fwd_s_q[0], fwd_prohibit_in};
        rev_s_d = {rev_s_q[0], rev_prohibit_in};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_s_q <= `SSO_SYNC_RESET;
            rev_s_q <= `SSO_SYNC_RESET;
        end else begin
            fwd_s_q <= fwd_s_d;
            rev_s_q <= rev_s_d;
        end
    end

    assign fwd_seen = fwd_s_q[1];
    assign rev_seen = rev_s_q[1];

    // ************************************************************
    // Status functions, active low except overtravel, which is high while an enabled prohibit is seen
    // ************************************************************
    logic [8:0] fn_n;
    logic travel_n;
    logic excite_n;
    logic tqlim_n;
    logic turning_n;
    logic fwd_active;
    logic rev_active;

    always_comb begin
        // A disabled input is ignored; with both disabled the output stays low.
        fwd_active = fwd_seen && !fwd_dis_q;
        rev_active = rev_seen && !rev_dis_q;
        travel_n = fwd_active || rev_active;
        excite_n = !servo_excited;
        // No mode input is consulted, so the indication is the same in every mode.
        tqlim_n = !exceeds(torque_ref_abs, torque_limit_setting);
        turning_n = !exceeds(motor_speed_abs, rotation_detect_threshold);
    end

    always_comb begin
        fn_n = 9'h1ff;
        fn_n[`SSO_FN_INPOS] = !drive_status.in_position;
        fn_n[`SSO_FN_TURNING] = turning_n;
        fn_n[`SSO_FN_READY] = !drive_status.servo_ready;
        fn_n[`SSO_FN_TQLIM] = tqlim_n;
        fn_n[`SSO_FN_BRAKE] = !drive_status.brake_release;
        fn_n[`SSO_FN_INDEX] = !drive_status.index_pulse;
        fn_n[`SSO_FN_TRAVEL] = travel_n;
        fn_n[`SSO_FN_EXCITE] = excite_n;
        fn_n[`SSO_FN_HOME] = !drive_status.home_done;
    end

    // ************************************************************
    // Pin pair routing
    // ************************************************************
    sso_pkg::sso_pins_t pins_d;
    sso_pkg::sso_pins_t pins_q;
    logic [3:0] code_1112;
    logic [3:0] code_0506;
    logic [3:0] code_0910;

    always_comb begin
        code_1112 = digit_at({4'h0, sel_q}, `SSO_DIG_PAIR1112_LSB);
        code_0506 = digit_at({4'h0, sel_q}, `SSO_DIG_PAIR0506_LSB);
        code_0910 = digit_at({4'h0, sel_q}, `SSO_DIG_PAIR0910_LSB);
        // Factory selection picks 0, 1 and 2 only, so the new functions stay hidden.
        pins_d.pair_1112_n = pick_fn(code_1112, fn_n);
        pins_d.pair_0506_n = pick_fn(code_0506, fn_n);
        pins_d.pair_0910_n = pick_fn(code_0910, fn_n);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pins_q <= `SSO_PINS_RESET;
        end else begin
            pins_q <= pins_d;
        end
    end

    // ************************************************************
    // Dedicated status outputs
    // ************************************************************
    logic travel_q;
    logic travel_d;
    logic tqlim_q;
    logic tqlim_d;
    logic turning_q;
    logic turning_d;

    // One register stage keeps these in step with the routed pin pairs.
    always_comb begin
        travel_d = travel_n;
        tqlim_d = tqlim_n;
        turning_d = turning_n;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            travel_q <= `SSO_STAT_RESET;
            tqlim_q <= `SSO_STAT_RESET;
            turning_q <= `SSO_STAT_RESET;
        end else begin
            travel_q <= travel_d;
            tqlim_q <= tqlim_d;
            turning_q <= turning_d;
        end
    end

    // ************************************************************
    // Output wiring
    // ************************************************************
    assign pins_n = pins_q;
    assign overtravel_out = travel_q;
    assign torque_limit_out = tqlim_q;
    assign rotation_detect_out = turning_q;

endmodule : sso_top

// ---- tb/sso_chk.sv ----
// Assertions on the status output selector's output levels.
// Assumes the bench moves overtravel_setting only while reset is held.
`timescale 1ns/1ps
module sso_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] overtravel_setting,
    input wire logic fwd_prohibit_in,
    input wire logic rev_prohibit_in,
    input wire logic [15:0] torque_ref_abs,
    input wire logic [15:0] torque_limit_setting,
    input wire logic [15:0] motor_speed_abs,
    input wire logic [15:0] rotation_detect_threshold,
    input wire logic overtravel_out,
    input wire logic torque_limit_out,
    input wire logic rotation_detect_out
);
    wire logic fwd_off = overtravel_setting[7:4] == 4'h1;
    wire logic rev_off = overtravel_setting[11:8] == 4'h1;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Three edges of stable pins cover the two-stage synchroniser and the output flop.
    travel_clear_a: assert property (
        (!fwd_prohibit_in && !rev_prohibit_in)[*3] |=> !overtravel_out) else $error("travel");
    travel_fwd_a: assert property (
        (fwd_prohibit_in && !fwd_off)[*3] |=> overtravel_out) else $error("travel fwd");
    travel_rev_a: assert property (
        (rev_prohibit_in && !rev_off)[*3] |=> overtravel_out) else $error("travel rev");
    travel_mask_a: assert property (
        ((fwd_off || !fwd_prohibit_in) && (rev_off || !rev_prohibit_in))[*3]
        |=> !overtravel_out) else $error("travel mask");
    travel_both_a: assert property (
        $past(rst_n) && $past(rst_n, 2) && fwd_off && rev_off |-> !overtravel_out)
        else $error("travel both");
    torque_flag_a: assert property ($past(rst_n) |-> torque_limit_out ==
        !($past(torque_ref_abs) > $past(torque_limit_setting))) else $error("tl");
    rotation_flag_a: assert property ($past(rst_n) |-> rotation_detect_out ==
        !($past(motor_speed_abs) > $past(rotation_detect_threshold))) else $error("rot");
    reset_high_a: assert property ($rose(rst_n) |-> overtravel_out &&
        torque_limit_out && rotation_detect_out) else $error("reset");
endmodule : sso_chk
bind sso_top sso_chk i_sso_chk (.*);

// ---- tb/sso_host.sv ----
// Host controller model: holds references back during overtravel.
// Assumes overtravel_out is the drive's registered status level.
`timescale 1ns/1ps
module sso_host (
    input wire logic mclk,
    input wire logic overtravel_out,
    output logic ref_enable
);
    always_ff @(posedge mclk) ref_enable <= !overtravel_out;
endmodule : sso_host

// ---- tb/testbench.sv ----
// Random bench for the status output selector beside a host model.
// Assumes the select and overtravel settings are captured at the first edge after reset.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected %0t %h %h", $time, a, b); end end
module testbench;
    logic mclk = 0, rst_n = 0, fwd = 0, rev = 0, exc = 0, ref_en, trav_n, tl_n, rot_n;
    logic [11:0] sel = 12'h210, cap;
    logic [15:0] ots = 16'h0, thr = 16'h14, trq = '0, lim = '0, spd = '0;
    logic [31:0] rnd = 32'h729bbda6;
    sso_pkg::sso_drive_status_t ds = '0;
    sso_pkg::sso_pins_t pins_n;
    int n_mismatch = 0, check_count = 0;
    wire logic trav_x = (fwd && ots[7:4] != 4'h1) || (rev && ots[11:8] != 4'h1);
    wire logic [8:0] act = {ds.home_done, exc, trav_x, ds.index_pulse, ds.brake_release,
        trq > lim, ds.servo_ready, spd > thr, ds.in_position};
    sso_top i_sso_top (.mclk(mclk), .rst_n(rst_n), .output_select_setting(sel),
        .overtravel_setting(ots), .rotation_detect_threshold(thr), .fwd_prohibit_in(fwd),
        .rev_prohibit_in(rev), .servo_excited(exc), .torque_ref_abs(trq), .pins_n(pins_n),
        .torque_limit_setting(lim), .motor_speed_abs(spd), .drive_status(ds),
        .overtravel_out(trav_n), .torque_limit_out(tl_n), .rotation_detect_out(rot_n));
    sso_host i_sso_host (.mclk(mclk), .overtravel_out(trav_n), .ref_enable(ref_en));
    always #12.5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic pe(input logic [3:0] c);
        return (c > 4'h8) ? 1'b1 : (c == 4'h6) ? act[6] : !act[c];
    endfunction : pe
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #75000 n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge mclk);
        #2;
        for (int k = 0; k < 40; k++) begin
            rst_n = 0;
            sel = k ? {4'((k + 7) % 10), 4'((k + 3) % 10), 4'(k % 10)} : 12'h210;
            ots = {7'h0, k[1], 3'h0, k[0], 4'h0};
            @(posedge mclk) #2 rst_n = 1;
            @(posedge mclk) #2 cap = sel;
            // A late change must be ignored until the next restart.
            sel = rnd[11:0];
            repeat (6) begin
                rnd = xs(rnd);
                {fwd, rev, exc, ds} = rnd[31:24];
                {trq, lim} = {12'h0, rnd[3:0], 12'h0, rnd[7:4]};
                {spd, thr} = {11'h0, rnd[12:8], 11'h0, rnd[20:16]};
                repeat (4) @(posedge mclk);
                #2;
                `CHK(trav_n, trav_x)
                `CHK(tl_n, !(trq > lim))
                `CHK(rot_n, !(spd > thr))
                `CHK(ref_en, !trav_x)
                `CHK(pins_n.pair_1112_n, pe(cap[3:0]))
                `CHK(pins_n.pair_0506_n, pe(cap[7:4]))
                `CHK(pins_n.pair_0910_n, pe(cap[11:8]))
            end
        end
        tally_and_finish();
    end
endmodule : testbench
